/* File: rtl/nvsq_pkg.sv */
// Purpose: Shared constants for the nonvolatile store/recall host sequencer.
// Assumes: 40 MHz clock, asynchronous 15-bit address, 8-bit data memory.
// Notes:   Durations are parameters of the top so simulation can shorten them.
package nvsq_pkg;
    // =========================================================
    // Bus shape
    localparam int NVSQ_AW = 15;
    localparam int NVSQ_DW = 8;
    localparam int NVSQ_SEQ_BITS = 14;
    // =========================================================
    // Sequence addresses, lower fourteen bits only
    localparam logic [13:0] NVSQ_SEQ_A1 = 14'h0e38;
    localparam logic [13:0] NVSQ_SEQ_A2 = 14'h31c7;
    localparam logic [13:0] NVSQ_SEQ_A3 = 14'h03e0;
    localparam logic [13:0] NVSQ_SEQ_A4 = 14'h3c1f;
    localparam logic [13:0] NVSQ_SEQ_A5 = 14'h303f;
    localparam logic [13:0] NVSQ_SEQ_STORE = 14'h0fc0;
    localparam logic [13:0] NVSQ_SEQ_RECALL = 14'h0c63;
    // =========================================================
    // Timing
    localparam int NVSQ_CLK_NS = 25;
    localparam int NVSQ_CYC_NS = 100;
    localparam logic [3:0] NVSQ_CYC_CLKS =
        4'((NVSQ_CYC_NS + NVSQ_CLK_NS - 1) / NVSQ_CLK_NS);
    localparam int NVSQ_STORE_US = 10000;
    localparam int NVSQ_RECALL_US = 20;
    localparam int NVSQ_HRECALL_US = 40000;
    localparam logic [3:0] NVSQ_CNT_RESET = 4'h0;
    // =========================================================
    // Operations
    typedef enum logic [1:0] {
        NVSQ_OP_READ = 2'h0,
        NVSQ_OP_WRITE = 2'h1,
        NVSQ_OP_STORE = 2'h2,
        NVSQ_OP_RECALL = 2'h3
    } nvsq_op_t;
endpackage

/* File: rtl/nvsq_cycle.sv */
// Purpose: One select-controlled read or write cycle on the memory pins.
// Assumes: Pins are driven straight from flip-flops.
// Notes:   Write strobe stays high on reads so sequence reads stay valid.
`timescale 1ns/1ps
`default_nettype none
module nvsq_cycle
    import nvsq_pkg::*;
(
    input wire logic clk, // Clock.
    input wire logic resetn, // Asynchronous reset, low.
    input wire logic start, // Begin a cycle, one-cycle pulse.
    input wire logic wr, // High for write.
    input wire logic [NVSQ_AW-1:0] addr, // Cycle address.
    input wire logic [NVSQ_DW-1:0] wdata, // Write data.
    input wire logic use_oe, // Drive output enable on reads.
    input wire logic [NVSQ_DW-1:0] dq_in, // Data pins in.
    output logic busy, // Cycle in progress.
    output logic done, // Cycle end pulse.
    output logic [NVSQ_DW-1:0] rdata, // Captured read data.
    output logic ce_n, // Select, low.
    output logic we_n, // Write strobe, low.
    output logic oe_n, // Output enable, low.
    output logic [NVSQ_AW-1:0] a, // Address pins.
    output logic [NVSQ_DW-1:0] dq_out, // Data pins out.
    output logic dq_oe // Host drives data pins.
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [3:0] cnt;
        logic [NVSQ_DW-1:0] rdata;
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic [NVSQ_AW-1:0] a;
        logic [NVSQ_DW-1:0] dq_out;
        logic dq_oe;
    } nvsq_cyc_t;
    nvsq_cyc_t s;
    nvsq_cyc_t next_s;
    // =========================================================
    // Cycle timing: select held low for a fixed count of clocks.
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        if (!s.busy && start) begin
            next_s.busy = 1'b1;
            next_s.cnt = NVSQ_CYC_CLKS;
            next_s.a = addr;
            next_s.ce_n = 1'b0;
            next_s.we_n = ~wr;
            next_s.oe_n = wr | ~use_oe;
            next_s.dq_out = wdata;
            next_s.dq_oe = wr;
        end else if (s.busy) begin
            if (s.cnt == 4'h1) begin
                // Sample before select rises; data still valid here.
                next_s.rdata = dq_in;
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
                next_s.ce_n = 1'b1;
                next_s.we_n = 1'b1;
                next_s.oe_n = 1'b1;
                next_s.dq_oe = 1'b0;
            end
            next_s.cnt = s.cnt - 4'h1;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '{busy: 1'b0, done: 1'b0, cnt: NVSQ_CNT_RESET,
                   rdata: '0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                   a: '0, dq_out: '0, dq_oe: 1'b0};
        end else begin
            s <= next_s;
        end
    end
    assign busy = s.busy;
    assign done = s.done;
    assign rdata = s.rdata;
    assign ce_n = s.ce_n;
    assign we_n = s.we_n;
    assign oe_n = s.oe_n;
    assign a = s.a;
    assign dq_out = s.dq_out;
    assign dq_oe = s.dq_oe;
    // Write strobe never falls while output enable is low.
    chk_we_oe_excl: assert property (@(posedge clk) disable iff (!resetn)
        !(!we_n && !oe_n)) else $error("write strobe with output enable");
    // Every cycle ends within the fixed length.
    chk_cycle_len: assert property (@(posedge clk) disable iff (!resetn)
        (start && !busy) |=> busy [*4] ##1 done)
        else $error("cycle length wrong");
endmodule
`default_nettype wire

/* File: rtl/nvsq_host.sv */
// Purpose: Host controller issuing reads, writes, stores and recalls.
// Assumes: Caller waits for ready; supply flags come from a monitor.
// Notes:   Durations are parameters so simulation can shorten them.
// Function
// - Host keeps strobes high during power-up recall.
// - Store is six reads in order ending at the store terminator.
// - Recall uses the same five reads then the recall terminator.
// - Every sequence step is a select-controlled read.
// - Write strobe stays high for all six cycles.
`timescale 1ns/1ps
`default_nettype none
module nvsq_host
    import nvsq_pkg::*;
#(
    parameter int STORE_CLKS = NVSQ_STORE_US * 40,
    parameter int RECALL_CLKS = NVSQ_RECALL_US * 40,
    parameter int HRECALL_CLKS = NVSQ_HRECALL_US * 40
) (
    input wire logic clk, // Clock, 40 MHz.
    input wire logic resetn, // Asynchronous reset, low.
    input wire logic req, // Request pulse, taken when ready.
    input wire nvsq_op_t op, // Requested operation.
    input wire logic [NVSQ_AW-1:0] req_addr, // Access address.
    input wire logic [NVSQ_DW-1:0] req_wdata, // Write data.
    input wire logic use_oe, // Assert output enable on reads.
    input wire logic supply_ok, // Supply above sense voltage.
    input wire logic [NVSQ_DW-1:0] dq_in, // Data pins in.
    output logic ready, // Idle and accepting requests.
    output logic resp_valid, // Request finished, pulse.
    output logic resp_err, // Error flag, held low; low-supply requests get no response.
    output logic [NVSQ_DW-1:0] resp_rdata, // Read data.
    output logic ce_n, // Select, low.
    output logic we_n, // Write strobe, low.
    output logic oe_n, // Output enable, low.
    output logic [NVSQ_AW-1:0] a, // Address pins.
    output logic [NVSQ_DW-1:0] dq_out, // Data pins out.
    output logic dq_oe // Host drives data pins.
);
    typedef enum logic [3:0] {
        NVSQ_POWERUP = 4'b0001,
        NVSQ_IDLE = 4'b0010,
        NVSQ_ACCESS = 4'b0100,
        NVSQ_WAIT = 4'b1000
    } nvsq_state_t;
    typedef struct packed {
        nvsq_state_t st;
        logic [31:0] wait_cnt;
        logic [2:0] step;
        logic seq;
        logic is_store;
        logic ready;
        logic resp_valid;
        logic resp_err;
        logic [NVSQ_DW-1:0] resp_rdata;
        logic launched;
        logic wr;
        logic oe;
        logic [NVSQ_AW-1:0] addr;
        logic [NVSQ_DW-1:0] wdata;
    } nvsq_host_s_t;
    nvsq_host_s_t s;
    nvsq_host_s_t next_s;
    logic cyc_busy;
    logic cyc_done;
    logic cyc_start;
    logic cyc_wr;
    logic [NVSQ_AW-1:0] cyc_addr;
    logic [NVSQ_DW-1:0] cyc_rdata;

    // Sequence address for a step; the fifteenth bit is held low.
    function automatic logic [NVSQ_AW-1:0] seq_addr(
        input logic [2:0] step, input logic store);
        logic [13:0] v;
        v = NVSQ_SEQ_A1;
        case (step)
            3'h0: v = NVSQ_SEQ_A1;
            3'h1: v = NVSQ_SEQ_A2;
            3'h2: v = NVSQ_SEQ_A3;
            3'h3: v = NVSQ_SEQ_A4;
            3'h4: v = NVSQ_SEQ_A5;
            default: v = store ? NVSQ_SEQ_STORE : NVSQ_SEQ_RECALL;
        endcase
        seq_addr = {1'b0, v};
    endfunction

    // =========================================================
    // Pin cycle engine
    nvsq_cycle u_cycle (
        .clk(clk),
        .resetn(resetn),
        .start(cyc_start),
        .wr(cyc_wr),
        .addr(cyc_addr),
        .wdata(s.wdata),
        .use_oe(s.oe),
        .dq_in(dq_in),
        .busy(cyc_busy),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .ce_n(ce_n),
        .we_n(we_n),
        .oe_n(oe_n),
        .a(a),
        .dq_out(dq_out),
        .dq_oe(dq_oe)
    );

    // Sequence cycles are always reads, run back to back with nothing
    // interleaved, because requests are refused until the sequence ends.
    assign cyc_start = (s.st == NVSQ_ACCESS) && !s.launched;
    // Request fields are latched at the take, since req is only a pulse.
    assign cyc_wr = !s.seq && s.wr;
    assign cyc_addr = s.seq ? seq_addr(s.step, s.is_store) : s.addr;

    // =========================================================
    // Operation sequencing.
    always_comb begin
        next_s = s;
        next_s.resp_valid = 1'b0;
        case (s.st)
            NVSQ_POWERUP: begin
                // Strobes stay high while the device recalls on its own.
                if (s.wait_cnt == 32'h0) begin
                    next_s.st = NVSQ_IDLE;
                    next_s.ready = 1'b1;
                end else if (supply_ok) begin
                    next_s.wait_cnt = s.wait_cnt - 32'h1;
                end else begin
                    next_s.wait_cnt = 32'(HRECALL_CLKS);
                end
            end
            NVSQ_IDLE: begin
                if (!supply_ok) begin
                    // Low supply relatches the device recall request.
                    next_s.st = NVSQ_POWERUP;
                    next_s.ready = 1'b0;
                    next_s.wait_cnt = 32'(HRECALL_CLKS);
                end else if (req) begin
                    next_s.ready = 1'b0;
                    next_s.step = 3'h0;
                    next_s.launched = 1'b0;
                    next_s.seq = (op == NVSQ_OP_STORE) ||
                                 (op == NVSQ_OP_RECALL);
                    next_s.is_store = (op == NVSQ_OP_STORE);
                    next_s.wr = (op == NVSQ_OP_WRITE);
                    next_s.oe = use_oe;
                    next_s.addr = req_addr;
                    next_s.wdata = req_wdata;
                    next_s.st = NVSQ_ACCESS;
                    // Device would inhibit these, so do not try.
                    if (op == NVSQ_OP_WRITE || op == NVSQ_OP_STORE) begin
                        if (!supply_ok) begin
                            next_s.st = NVSQ_IDLE;
                        end
                    end
                end
            end
            NVSQ_ACCESS: begin
                if (cyc_start) begin
                    next_s.launched = 1'b1;
                end
                if (cyc_done) begin
                    next_s.resp_rdata = cyc_rdata;
                    next_s.launched = 1'b0;
                    if (s.seq && s.step != 3'h5) begin
                        next_s.step = s.step + 3'h1;
                    end else if (s.seq) begin
                        // Device now busy; pins must stay idle.
                        next_s.st = NVSQ_WAIT;
                        next_s.wait_cnt = s.is_store ?
                            32'(STORE_CLKS) : 32'(RECALL_CLKS);
                    end else begin
                        next_s.st = NVSQ_IDLE;
                        next_s.ready = 1'b1;
                        next_s.resp_valid = 1'b1;
                        next_s.resp_err = 1'b0;
                    end
                end
            end
            NVSQ_WAIT: begin
                if (s.wait_cnt == 32'h0) begin
                    next_s.st = NVSQ_IDLE;
                    next_s.ready = 1'b1;
                    next_s.resp_valid = 1'b1;
                    next_s.resp_err = 1'b0;
                end else begin
                    next_s.wait_cnt = s.wait_cnt - 32'h1;
                end
            end
            default: begin
                next_s.st = NVSQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '{st: NVSQ_POWERUP, wait_cnt: 32'(HRECALL_CLKS),
                   step: 3'h0, seq: 1'b0, is_store: 1'b0, ready: 1'b0,
                   resp_valid: 1'b0, resp_err: 1'b0, resp_rdata: '0,
                   launched: 1'b0, wr: 1'b0, oe: 1'b0, addr: '0,
                   wdata: '0};
        end else begin
            s <= next_s;
        end
    end
    assign ready = s.ready;
    assign resp_valid = s.resp_valid;
    assign resp_err = s.resp_err;
    assign resp_rdata = s.resp_rdata;

    // =========================================================
    // Checks
    // A sequence step on the pins: selected with the write strobe high.
    sequence seq_step_read;
        !ce_n && we_n;
    endsequence
    chk_powerup_idle: assert property (@(posedge clk) disable iff (!resetn)
        (s.st == NVSQ_POWERUP) |-> (ce_n && we_n))
        else $error("pins active during power-up recall");
    chk_seq_reads: assert property (@(posedge clk) disable iff (!resetn)
        (cyc_start && s.seq) |=> seq_step_read)
        else $error("sequence step not a read");
    chk_we_high_seq: assert property (@(posedge clk) disable iff (!resetn)
        (s.seq && s.st == NVSQ_ACCESS) |-> we_n)
        else $error("write strobe low in sequence");
    chk_addr_bit14: assert property (@(posedge clk) disable iff (!resetn)
        (s.seq && !ce_n) |-> !a[14])
        else $error("top address bit set in sequence");
    chk_first_addr: assert property (@(posedge clk) disable iff (!resetn)
        (cyc_start && s.seq && s.step == 3'h0)
        |=> (a[13:0] == NVSQ_SEQ_A1))
        else $error("wrong first sequence address");
    chk_term_addr: assert property (@(posedge clk) disable iff (!resetn)
        (cyc_start && s.seq && s.step == 3'h5)
        |=> (a[13:0] == (s.is_store ? NVSQ_SEQ_STORE
                                    : NVSQ_SEQ_RECALL)))
        else $error("wrong terminator address");
    chk_wait_quiet: assert property (@(posedge clk) disable iff (!resetn)
        (s.st == NVSQ_WAIT) |-> ce_n)
        else $error("access during store or recall");
    chk_no_ready_seq: assert property (@(posedge clk) disable iff (!resetn)
        (s.seq && s.st == NVSQ_ACCESS) |-> !ready)
        else $error("request accepted inside sequence");
endmodule
`default_nettype wire

/* File: verification/nvsq_mem_model.sv */
// Purpose: Behavioural model of the nonvolatile memory facing the host.
// Assumes: Pins sampled on the bench clock; cap_ok high above sense level.
// Notes:   Released data lines toggle so a stale byte never passes.
`timescale 1ns/1ps
`default_nettype none
module nvsq_mem_model
    import nvsq_pkg::*;
#(
    parameter int STORE_CLKS = 20,
    parameter int RECALL_CLKS = 20,
    parameter int HRECALL_CLKS = 20
) (
    input wire logic clk, // Bench clock.
    input wire logic cap_ok, // Storage cap above sense level.
    input wire logic ce_n, // Select, low.
    input wire logic we_n, // Write strobe, low.
    input wire logic oe_n, // Output enable, low.
    input wire logic [NVSQ_AW-1:0] a, // Address.
    input wire logic [NVSQ_DW-1:0] dq_out, // Host data.
    input wire logic dq_oe, // Host drives data.
    output logic [NVSQ_DW-1:0] dq_in, // Device data.
    output logic [7:0] n_store, // Stores started.
    output logic [7:0] n_recall, // Software recalls started.
    output logic [7:0] n_hrecall, // Power-up recalls started.
    output logic [7:0] n_ignored // Selects seen while busy.
);
    logic [7:0] mem [0:32767];
    logic [7:0] nv [0:32767];
    logic [13:0] seq [0:4];
    logic [7:0] last_q;
    logic [7:0] wdat;
    logic [14:0] cyc_a;
    logic pend, busy, in_cyc, wr_seen, prev_ce;
    int cnt, step, kind;
    // ==========================================================
    // Start an operation; erase or clear happens first.
    task automatic start(input int k, input int n);
        kind = k;
        cnt = n;
        busy = 1'b1;
        step = 0;
        for (int i = 0; i < 32768; i++) begin
            if (k == 1) nv[i] = 8'hff;
            else mem[i] = 8'h00;
        end
    endtask
    // Power-up latches a recall request.
    initial begin
        seq = '{NVSQ_SEQ_A1, NVSQ_SEQ_A2, NVSQ_SEQ_A3, NVSQ_SEQ_A4, NVSQ_SEQ_A5};
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 8'h00;
            nv[i] = 8'h00;
        end
        {n_store, n_recall, n_hrecall, n_ignored} = 32'h0;
        {busy, in_cyc, wr_seen, step, last_q} = '0;
        pend = 1'b1;
        prev_ce = 1'b1;
    end
    // Output only while selected for a read; no pull, so drive junk.
    assign dq_in = (!ce_n && !oe_n && we_n && !busy) ? mem[a] : ~last_q;
    // Cycles are judged at the rise of select, when the whole cycle is known.
    always @(posedge clk) begin
        // Updated late so the host never sees the junk move at its edge.
        last_q <= dq_in;
        if (!cap_ok) pend = 1'b1;
        if (busy) begin
            if (prev_ce && !ce_n) n_ignored++;
            cnt--;
            if (cnt == 0) begin
                busy = 1'b0;
                for (int i = 0; i < 32768; i++) begin
                    if (kind == 1) nv[i] = mem[i];
                    else mem[i] = nv[i];
                end
            end
        end else if (pend && cap_ok) begin
            start(3, HRECALL_CLKS);
            pend = 1'b0;
            n_hrecall++;
        end else begin
            if (prev_ce && !ce_n) begin
                in_cyc = 1'b1;
                wr_seen = 1'b0;
                cyc_a = a;
            end
            if (in_cyc && !ce_n && !we_n) begin
                wr_seen = 1'b1;
                wdat = dq_oe ? dq_out : ~last_q;
            end
            if (in_cyc && ce_n) begin
                in_cyc = 1'b0;
                if (wr_seen) begin
                    if (cap_ok) mem[cyc_a] = wdat;
                    step = 0;
                end else if (step == 5 && cyc_a[13:0] == NVSQ_SEQ_STORE
                             && cap_ok) begin
                    start(1, STORE_CLKS);
                    n_store++;
                end else if (step == 5 && cyc_a[13:0] == NVSQ_SEQ_RECALL) begin
                    start(2, RECALL_CLKS);
                    n_recall++;
                end else if (step < 5 && cyc_a[13:0] == seq[step]) begin
                    step++;
                end else begin
                    step = (cyc_a[13:0] == seq[0]) ? 1 : 0;
                end
            end
        end
        prev_ce = ce_n;
    end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the store/recall host sequencer.
// Assumes: Durations shortened to 20 clocks on both sides.
// Notes:   Inputs change on the falling edge only.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import nvsq_pkg::*;
    localparam int SHORT = 20;
    localparam nvsq_op_t R = NVSQ_OP_READ;
    localparam nvsq_op_t W = NVSQ_OP_WRITE;
    localparam nvsq_op_t S = NVSQ_OP_STORE;
    localparam nvsq_op_t C = NVSQ_OP_RECALL;
    typedef struct packed {
        nvsq_op_t op;
        logic [14:0] ad;
        logic [7:0] d;
        logic [7:0] st;
        logic [7:0] rc;
    } nvsq_row_t;
    // Operation, address, write or expected read data, store and recall counts.
    nvsq_row_t rows [18] = '{
        '{W, 15'h0100, 8'h5a, 8'h0, 8'h0}, '{R, 15'h0100, 8'h5a, 8'h0, 8'h0},
        '{S, 15'h0000, 8'h00, 8'h1, 8'h0}, '{W, 15'h0100, 8'h33, 8'h1, 8'h0},
        '{R, 15'h0100, 8'h33, 8'h1, 8'h0}, '{C, 15'h0000, 8'h00, 8'h1, 8'h1},
        '{R, 15'h0100, 8'h5a, 8'h1, 8'h1}, '{C, 15'h0000, 8'h00, 8'h1, 8'h2},
        '{R, 15'h0100, 8'h5a, 8'h1, 8'h2}, '{S, 15'h0000, 8'h00, 8'h2, 8'h2},
        '{R, 15'h0e38, 8'h00, 8'h2, 8'h2}, '{R, 15'h31c7, 8'h00, 8'h2, 8'h2},
        '{R, 15'h03e0, 8'h00, 8'h2, 8'h2}, '{R, 15'h3c1f, 8'h00, 8'h2, 8'h2},
        '{R, 15'h303f, 8'h00, 8'h2, 8'h2}, '{W, 15'h0200, 8'h77, 8'h2, 8'h2},
        '{R, 15'h0fc0, 8'h00, 8'h2, 8'h2}, '{S, 15'h0000, 8'h00, 8'h3, 8'h2}};
    logic clk, resetn, req, use_oe, supply_ok;
    nvsq_op_t op;
    logic [14:0] req_addr, a;
    logic [7:0] req_wdata, dq_in, resp_rdata, dq_out;
    logic ready, resp_valid, resp_err, ce_n, we_n, oe_n, dq_oe;
    logic [7:0] n_store, n_recall, n_hrecall, n_ignored;
    int err_total, total_checks;
    // ==========================================================
    nvsq_host #(.STORE_CLKS(SHORT), .RECALL_CLKS(SHORT),
                .HRECALL_CLKS(SHORT)) i_nvsq_host (.clk(clk), .resetn(resetn),
        .req(req), .op(op), .req_addr(req_addr), .req_wdata(req_wdata),
        .use_oe(use_oe), .supply_ok(supply_ok), .dq_in(dq_in), .ready(ready),
        .resp_valid(resp_valid), .resp_err(resp_err), .resp_rdata(resp_rdata),
        .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .a(a), .dq_out(dq_out),
        .dq_oe(dq_oe));
    nvsq_mem_model #(.STORE_CLKS(SHORT), .RECALL_CLKS(SHORT),
                     .HRECALL_CLKS(SHORT)) i_nvsq_mem_model (.clk(clk),
        .cap_ok(supply_ok), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .a(a),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .n_store(n_store),
        .n_recall(n_recall), .n_hrecall(n_hrecall), .n_ignored(n_ignored));
    // 40 MHz clock.
    always #12.5 clk = ~clk;
    // ==========================================================
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp,
                            input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s is %b", $time, what, got);
        end
    endtask
    // Bounded waits; a hang ends the run through the report.
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 400) begin
            cmp_bit(we_n, 1'b1, "strobe while not ready");
            @(negedge clk);
            n++;
        end
        if (ready !== 1'b1) begin
            err_total++;
            $display("wrong value at %0t: ready never came", $time);
            wrap_up();
        end
    endtask
    task automatic issue(input nvsq_op_t o, input logic [14:0] ad,
                         input logic [7:0] wd, input logic oe);
        int n;
        wait_ready();
        req = 1'b1;
        op = o;
        req_addr = ad;
        req_wdata = wd;
        use_oe = oe;
        @(negedge clk);
        req = 1'b0;
        n = 0;
        while (resp_valid !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (resp_valid !== 1'b1) begin
            err_total++;
            $display("wrong value at %0t: no response", $time);
            wrap_up();
        end
        cmp_bit(resp_err, 1'b0, "error flag");
    endtask
    // Reset, table of ordinary cases, then supply loss by hand.
    initial begin
        {clk, resetn, req, req_addr, req_wdata, err_total, total_checks} = '0;
        op = R;
        use_oe = 1'b1;
        supply_ok = 1'b1;
        repeat (6) @(negedge clk);
        cmp_bit(we_n, 1'b1, "strobe in reset");
        cmp_bit(ready, 1'b0, "ready in reset");
        resetn = 1'b1;
        wait_ready();
        cmp_byte(n_hrecall, 8'h1, "power-up recall");
        foreach (rows[i]) begin
            issue(rows[i].op, rows[i].ad, rows[i].d, rows[i].op < S);
            if (rows[i].op == R) cmp_byte(resp_rdata, rows[i].d, "read");
            cmp_byte(n_store, rows[i].st, "stores");
            cmp_byte(n_recall, rows[i].rc, "recalls");
        end
        supply_ok = 1'b0;
        repeat (4) @(negedge clk);
        cmp_bit(ready, 1'b0, "ready on low supply");
        req = 1'b1;
        op = W;
        req_addr = 15'h0300;
        req_wdata = 8'h99;
        @(negedge clk);
        req = 1'b0;
        repeat (10) begin
            @(negedge clk);
            cmp_bit(ce_n, 1'b1, "select on low supply");
        end
        supply_ok = 1'b1;
        wait_ready();
        cmp_byte(n_hrecall, 8'h2, "second power-up recall");
        issue(R, 15'h0200, 8'h00, 1'b1);
        cmp_byte(resp_rdata, 8'h77, "stored byte");
        issue(R, 15'h0300, 8'h00, 1'b1);
        cmp_byte(resp_rdata, 8'h00, "inhibited write");
        cmp_byte(n_ignored, 8'h0, "access while busy");
        wrap_up();
    end
endmodule
`default_nettype wire
